// file: dshbp_dev_model.sv
/* Behavioural model of the framer's parallel port, as the host sees it.
 Assumes the bench resolves the open-drain and shared bus lines. */
module dshbp_dev_model (
   // Strap, reset and bench control
   input  wire logic       style,
   input  wire logic       rst_n,
   input  wire logic       irq_req,
   input  var  int         ack_dly,
   // Host pins
   input  wire logic [8:0] addr,
   input  wire logic [7:0] ad,
   input  wire logic       ale,
   input  wire logic       cs_n,
   input  wire logic       ds_n,
   input  wire logic       rw_n,
   // Device drivers
   output logic [7:0]      ad_dev,
   output logic            ad_oe,
   output logic            ack_oe,
   output logic            irq_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [512];
   logic [8:0] lat;
   logic [8:0] a;
   logic       act;
   logic       rd;
   initial ack_oe = 1'b0;
   initial ad_oe = 1'b0;
   assign irq_oe = irq_req;
   assign rd = style ? !ds_n : rw_n;
   assign a = style ? lat : addr;
   assign act = !cs_n && (style ? (!ds_n || !rw_n) : !ds_n);
   always @(negedge ale) if (style) lat = {addr[8], ad};
   always @(negedge rst_n) foreach (mem[i]) mem[i] = 8'(i) ^ 8'ha5;
   always begin
      wait (act === 1'b1);
      if (ack_dly >= 0) #(ack_dly);
      if (act && ack_dly >= 0) begin
         if (rd) begin
            ad_dev = mem[a];
            ad_oe = 1'b1;
         end else mem[a] = ad;
         ack_oe = 1'b1;
      end
      wait (act !== 1'b1);
      ack_oe = 1'b0;
      ad_oe = 1'b0;
   end
endmodule : dshbp_dev_model

// file: dshbp_host.sv
/*
 Host controller that drives the framer's parallel port in either bus style.
 Assumes the strap level is stable and matches the device's strap pin.
*/
// Operation
// R1: Separate style: data-only bus, 9-bit address, data strobe, read high.
// R2: Muxed style: shared address/data, low read strobe, low write strobe.
// R3: Muxed style: top address bit still on its own pin.
// R4: Muxed style: address held on bus before latch strobe falls.
// R5: Chip select low opens a cycle; high ends it and frees bus.
// R6: Device pulls interrupt low while any request is pending.
// R7: Device pulls acknowledge low during transfer cycle.
// R8: Device reset returns all port registers to defaults.
// R9: Device releases acknowledge once strobe or chip select ends.
module dshbp_host #(
   parameter int ACK_TIMEOUT = dshbp_pkg::ACK_TO_CYC
) (
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       RST_N,
   // User request
   input  wire logic       REQ_VALID,
   output logic            REQ_READY,
   input  wire logic       REQ_WRITE,
   input  wire logic [8:0] REQ_ADDR,
   input  wire logic [7:0] REQ_WDATA,
   output logic            RSP_VALID,
   output logic [7:0]      RSP_RDATA,
   output logic            RSP_TIMEOUT,
   output logic            IRQ,
   // Strap and device reset
   input  wire logic       BUS_STYLE_SELECT,
   output logic            DEV_RESET_N,
   input  wire logic       DEV_RESET_REQ,
   // Device pins
   output logic [8:0]      ADDR,
   input  wire logic [7:0] AD_I,
   output logic [7:0]      AD_O,
   output logic            AD_OE,
   output logic            ALE,
   output logic            CS_N,
   output logic            DATA_OR_READ_STROBE_N,
   output logic            RW_OR_WRITE_STROBE_N,
   input  wire logic       TRANSFER_ACK_N,
   input  wire logic       IRQ_N
);
   if (ACK_TIMEOUT < 2 || ACK_TIMEOUT > 255) begin : g_bad_timeout
      $error("ACK_TIMEOUT out of range");
   end

   typedef enum {ST_IDLE, ST_ALE, ST_SETUP, ST_WAIT, ST_HOLD} dshbp_st_t;
   dshbp_st_t st;
   dshbp_st_t next_st;

   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic       wr;
   logic       next_wr;
   logic       next_ale;
   logic       next_cs_n;
   logic       next_ds_n;
   logic       next_rw_n;
   logic       next_ad_oe;
   logic [7:0] next_ad_o;
   logic [8:0] next_addr;
   logic       next_rsp_valid;
   logic       next_rsp_timeout;
   logic [7:0] next_rsp_rdata;
   logic       ack_n_s;
   logic       irq_n_s;
   logic       muxed;

   dshbp_sync #(.INIT(1'b1)) u_ack (
      .CLK  (CLK),
      .RST_N(RST_N),
      .d    (TRANSFER_ACK_N),
      .q    (ack_n_s)
   );
   dshbp_sync #(.INIT(1'b1)) u_irq (
      .CLK  (CLK),
      .RST_N(RST_N),
      .d    (IRQ_N),
      .q    (irq_n_s)
   );

   assign muxed = (BUS_STYLE_SELECT == dshbp_pkg::BUS_MUXED);
   assign REQ_READY = (st == ST_IDLE) && ack_n_s;
   assign IRQ = !irq_n_s; // R6
   assign DEV_RESET_N = !DEV_RESET_REQ; // R8

   always_comb begin
      next_st = st;
      next_cnt = cnt;
      next_wr = wr;
      next_ale = ALE;
      next_cs_n = CS_N;
      next_ds_n = DATA_OR_READ_STROBE_N;
      next_rw_n = RW_OR_WRITE_STROBE_N;
      next_ad_oe = AD_OE;
      next_ad_o = AD_O;
      next_addr = ADDR;
      next_rsp_valid = 1'b0;
      next_rsp_timeout = RSP_TIMEOUT;
      next_rsp_rdata = RSP_RDATA;
      unique case (st)
         ST_IDLE: begin
            if (REQ_VALID && REQ_READY) begin
               next_wr = REQ_WRITE;
               next_addr = REQ_ADDR; // R1 R3
               next_cnt = 8'(dshbp_pkg::SETUP_CYC);
               next_rsp_timeout = 1'b0;
               if (muxed) begin
                  next_ad_o = REQ_ADDR[7:0]; // R4
                  next_ad_oe = 1'b1;
                  next_ale = 1'b1;
                  next_st = ST_ALE;
               end else begin
                  next_ad_o = REQ_WDATA;
                  next_ad_oe = REQ_WRITE;
                  next_rw_n = !REQ_WRITE; // R1
                  next_cs_n = 1'b0; // R5
                  next_st = ST_SETUP;
               end
            end
         end
         ST_ALE: begin
            if (cnt > 8'h01) begin
               next_cnt = cnt - 8'h01;
            end else begin
               next_ale = 1'b0; // R4
               next_cnt = 8'(dshbp_pkg::SETUP_CYC);
               next_cs_n = 1'b0; // R5
               next_st = ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (muxed && cnt == 8'(dshbp_pkg::SETUP_CYC)) begin
               next_ad_o = REQ_WDATA;
            end
            if (cnt > 8'h01) begin
               next_cnt = cnt - 8'h01;
            end else begin
               if (muxed) begin
                  next_ad_oe = wr; // R2
                  next_ds_n = wr;
                  next_rw_n = !wr;
               end else begin
                  next_ds_n = 1'b0; // R1
               end
               next_cnt = 8'(ACK_TIMEOUT);
               next_st = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!ack_n_s || cnt == 8'h00) begin
               next_rsp_timeout = ack_n_s; // R7
               next_rsp_rdata = wr ? RSP_RDATA : AD_I;
               next_rsp_valid = 1'b1;
               next_ds_n = 1'b1;
               next_rw_n = 1'b1;
               next_cs_n = 1'b1; // R5
               next_ad_oe = 1'b0;
               next_st = ST_HOLD;
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         ST_HOLD: begin
            if (ack_n_s) begin
               next_st = ST_IDLE; // R9
            end
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         st <= ST_IDLE;
         cnt <= 8'h00;
         wr <= 1'b0;
         ALE <= 1'b0;
         CS_N <= 1'b1;
         DATA_OR_READ_STROBE_N <= 1'b1;
         RW_OR_WRITE_STROBE_N <= 1'b1;
         AD_OE <= 1'b0;
         AD_O <= 8'h00;
         ADDR <= 9'h000;
         RSP_VALID <= 1'b0;
         RSP_TIMEOUT <= 1'b0;
         RSP_RDATA <= 8'h00;
      end else begin
         st <= next_st;
         cnt <= next_cnt;
         wr <= next_wr;
         ALE <= next_ale;
         CS_N <= next_cs_n;
         DATA_OR_READ_STROBE_N <= next_ds_n;
         RW_OR_WRITE_STROBE_N <= next_rw_n;
         AD_OE <= next_ad_oe;
         AD_O <= next_ad_o;
         ADDR <= next_addr;
         RSP_VALID <= next_rsp_valid;
         RSP_TIMEOUT <= next_rsp_timeout;
         RSP_RDATA <= next_rsp_rdata;
      end
   end

   chk_cs_frees_bus: assert property (@(posedge CLK) disable iff (!RST_N)
      CS_N |-> !AD_OE || st == ST_ALE || st == ST_SETUP) // R5
      else $error("bus driven outside a cycle");
   chk_ale_before_cs: assert property (@(posedge CLK) disable iff (!RST_N)
      $fell(CS_N) && muxed |-> $past(ALE, 1) || $past(ALE, 2)) // R4
      else $error("muxed cycle without address latch");
   chk_muxed_rd_strobe: assert property (@(posedge CLK) disable iff (!RST_N)
      muxed && !DATA_OR_READ_STROBE_N |-> !CS_N && !wr && !AD_OE) // R2
      else $error("read strobe misuse");
   chk_sep_direction: assert property (@(posedge CLK) disable iff (!RST_N)
      !muxed && !CS_N |-> RW_OR_WRITE_STROBE_N == !wr) // R1
      else $error("direction line wrong");
   chk_addr_top_bit: assert property (@(posedge CLK) disable iff (!RST_N)
      REQ_VALID && REQ_READY |=> ADDR == $past(REQ_ADDR)) // R3
      else $error("address pins wrong");
   chk_muxed_addr_latch: assert property (@(posedge CLK) disable iff (!RST_N)
      muxed && $fell(ALE) |-> AD_OE && AD_O == ADDR[7:0]) // R4
      else $error("address not on bus at latch");
   chk_ack_ends: assert property (@(posedge CLK) disable iff (!RST_N)
      st == ST_WAIT && !ack_n_s |=> CS_N && RSP_VALID) // R7
      else $error("acknowledge did not end cycle");
   chk_hold_release: assert property (@(posedge CLK) disable iff (!RST_N)
      st == ST_HOLD && ack_n_s |=> st == ST_IDLE) // R9
      else $error("hold not left on release");
   chk_irq_follow: assert property (@(posedge CLK) disable iff (!RST_N)
      !IRQ_N [*4] |=> IRQ) // R6
      else $error("interrupt not followed");
   chk_irq_release: assert property (@(posedge CLK) disable iff (!RST_N)
      IRQ_N [*4] |=> !IRQ) // R6
      else $error("interrupt not released");
   chk_dev_reset: assert property (@(posedge CLK) disable iff (!RST_N)
      DEV_RESET_REQ |-> !DEV_RESET_N) // R8
      else $error("device reset not driven");
   cov_read: cover property (@(posedge CLK) RSP_VALID && !wr && !RSP_TIMEOUT);
   cov_write: cover property (@(posedge CLK) RSP_VALID && wr);
   cov_timeout: cover property (@(posedge CLK) RSP_VALID && RSP_TIMEOUT);
endmodule : dshbp_host

// file: dshbp_pkg.sv
/*
 Constants for the host-side controller of the dual-style parallel port.
 Assumes a 50 MHz clock and a device that acknowledges each cycle.
*/
package dshbp_pkg;
   localparam int ADDR_W      = 9;
   localparam int DATA_W      = 8;
   localparam int CLK_MHZ     = 50;
   localparam int SETUP_NS    = 40;
   localparam int SETUP_CYC   = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int ACK_TO_NS   = 2000;
   localparam int ACK_TO_CYC  = (ACK_TO_NS * CLK_MHZ) / 1000;
   localparam int CNT_W       = 8;
   localparam logic BUS_SEPARATE = 1'b0;
   localparam logic BUS_MUXED    = 1'b1;
endpackage : dshbp_pkg

// file: dshbp_sync.sv
/*
 Three-stage synchroniser; a change counts once stages two and three agree.
 Assumes the input comes from outside the clock domain.
*/
module dshbp_sync #(
   parameter logic INIT = 1'b1
) (
   input  wire logic CLK,
   input  wire logic RST_N,
   input  wire logic d,
   output logic      q
);
   logic [2:0] s;
   logic [2:0] next_s;
   logic       next_q;

   always_comb begin
      next_s = {s[1:0], d};
      next_q = (s[1] == s[2]) ? s[2] : q;
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         s <= {3{INIT}};
         q <= INIT;
      end else begin
         s <= next_s;
         q <= next_q;
      end
   end
endmodule : dshbp_sync

// file: dual_style_host_bus_port_bench.sv
/* Self-checking bench for the dual-style host controller.
 Assumes the device model answers each cycle after ack_dly ns, and never while ack_dly is negative. */
module dual_style_host_bus_port_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk = 0, rst_n = 0, req_valid = 0, req_write = 0, style = 0;
   logic       dev_req = 0, irq_req = 0;
   logic [8:0] req_addr = 0;
   logic [7:0] req_wdata = 0;
   logic       req_ready, rsp_valid, rsp_to, irq, dev_rst_n, ad_oe, ale;
   logic       cs_n, ds_n, rw_n, dev_oe, ack_oe, irq_oe;
   logic [8:0] addr;
   logic [7:0] ad_o, rsp_rdata, dev_ad, ad_i;
   int         ack_dly = 30, n_mismatch = 0, check_count = 0;
   assign ad_i = ad_oe ? ad_o : (dev_oe ? dev_ad : 8'h00);
   initial forever #10 clk = !clk;
   dshbp_host #(.ACK_TIMEOUT(40)) i_dut (.CLK(clk), .RST_N(rst_n),
      .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_WRITE(req_write),
      .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid),
      .RSP_RDATA(rsp_rdata), .RSP_TIMEOUT(rsp_to), .IRQ(irq),
      .BUS_STYLE_SELECT(style), .DEV_RESET_N(dev_rst_n),
      .DEV_RESET_REQ(dev_req), .ADDR(addr), .AD_I(ad_i), .AD_O(ad_o),
      .AD_OE(ad_oe), .ALE(ale), .CS_N(cs_n), .DATA_OR_READ_STROBE_N(ds_n),
      .RW_OR_WRITE_STROBE_N(rw_n), .TRANSFER_ACK_N(!ack_oe),
      .IRQ_N(!irq_oe));
   dshbp_dev_model i_dev (.style(style), .rst_n(dev_rst_n),
      .irq_req(irq_req), .ack_dly(ack_dly), .addr(addr), .ad(ad_i),
      .ale(ale), .cs_n(cs_n), .ds_n(ds_n), .rw_n(rw_n), .ad_dev(dev_ad),
      .ad_oe(dev_oe), .ack_oe(ack_oe), .irq_oe(irq_oe));
   task automatic check(string what, logic [8:0] exp, logic [8:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check
   task automatic xfer(logic wr, logic [8:0] a, logic [7:0] d,
                       output logic [7:0] rd, output logic to);
      int n;
      n = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= wr;
      req_addr <= a;
      req_wdata <= d;
      do @(negedge clk); while (req_ready !== 1'b1 && ++n < 50);
      @(posedge clk);
      req_valid <= 1'b0;
      do @(negedge clk); while (rsp_valid !== 1'b1 && ++n < 300);
      rd = rsp_rdata;
      to = rsp_to;
      check("response", 9'h0, {8'h0, n >= 300});
   endtask : xfer
   task automatic restart(logic s);
      @(posedge clk);
      style <= s;
      rst_n <= 1'b0;
      dev_req <= 1'b1;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      dev_req <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : restart
   task automatic t_rw(logic s, int dly);
      logic [8:0] al [4] = '{9'h000, 9'h0ff, 9'h100, 9'h1ff};
      logic [7:0] r;
      logic       to;
      restart(s);
      ack_dly = dly;
      foreach (al[i]) xfer(1, al[i], {al[i][8], 7'h11} ^ al[i][7:0], r, to);
      foreach (al[i]) begin
         xfer(0, al[i], 8'h00, r, to);
         check("read data", {al[i][8], 7'h11} ^ al[i][7:0], r);
         check("timeout", 0, to);
      end
      xfer(0, 9'h155, 8'h00, r, to);
      check("default", 8'hf0, r);
      check("chip select", 1, cs_n);
      $display("read write test style %0d done", s);
   endtask : t_rw
   task automatic t_misc;
      logic [7:0] r;
      logic       to;
      xfer(1, 9'h0a5, 8'h77, r, to);
      @(posedge clk);
      dev_req <= 1'b1;
      @(negedge clk);
      check("device reset", 0, dev_rst_n);
      @(posedge clk) dev_req <= 1'b0;
      xfer(0, 9'h0a5, 8'h00, r, to);
      check("after reset", 8'h00, r);
      ack_dly = -1;
      xfer(0, 9'h003, 8'h00, r, to);
      check("timeout", 1, to);
      ack_dly = 30;
      xfer(0, 9'h003, 8'h00, r, to);
      check("recovered", 8'ha6, {to, r});
      @(posedge clk) irq_req <= 1'b1;
      repeat (6) @(negedge clk);
      check("irq set", 1, irq);
      @(posedge clk) irq_req <= 1'b0;
      repeat (6) @(negedge clk);
      check("irq clear", 0, irq);
      $display("reset timeout irq test done");
   endtask : t_misc
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   initial begin
      #(60000 * 20);
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      t_rw(0, 30);
      t_rw(1, 300);
      t_misc();
      report_and_stop();
   end
endmodule : dual_style_host_bus_port_bench
